/* hw/pstx_pkg.sv */
// pstx_pkg: constants and types for the sensor link transmitter
package pstx_pkg;
  // apb register byte offsets
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_ERR = 8'h0C;
  // config field positions
  localparam int CFG_CRC = 0;
  localparam int CFG_EMSG = 1;
  localparam int CFG_DEXT = 2;
  localparam int CFG_PDEN = 3;
  localparam int CFG_PROG = 4;
  localparam int CFG_INIT1 = 5;
  localparam int CFG_DAISY = 6;
  localparam int CFG_RUN = 7;
  localparam int CFG_FMT = 8;
  localparam int CFG_BLANK = 12;
  localparam int CFG_SEL = 16;
  localparam logic [31:0] CFG_RESET = 32'h0000_0060;
  // data source selects
  localparam logic [2:0] SEL_SENSOR = 3'h0;
  localparam logic [2:0] SEL_STATUS = 3'h1;
  localparam logic [2:0] SEL_ERROR = 3'h2;
  localparam logic [2:0] SEL_INITD = 3'h3;
  localparam logic [2:0] SEL_INITID = 3'h4;
  // data word codes
  localparam logic [9:0] CODE_BUSY = 10'h1E8;
  localparam logic [9:0] CODE_READY = 10'h1E7;
  localparam logic [9:0] CODE_UNLOCK = 10'h1E6;
  localparam logic [9:0] CODE_RC_OK = 10'h1E1;
  localparam logic [9:0] CODE_RC_ERR = 10'h1E2;
  localparam logic [9:0] CODE_COMM = 10'h1EF;
  localparam logic [9:0] CODE_TEST = 10'h1EE;
  localparam logic [9:0] CODE_PRESS = 10'h1ED;
  localparam logic [9:0] CODE_TEMP = 10'h1EC;
  localparam logic [9:0] CODE_MEM = 10'h1EB;
  localparam logic [9:0] CODE_SELFT = 10'h1EA;
  localparam logic [9:0] CODE_DEFECT = 10'h1F4;
  localparam logic [9:0] CODE_NIB_BASE = 10'h210;
  localparam logic [9:0] CODE_ID_BASE = 10'h200;
  localparam logic [9:0] SENS_MAX = 10'h133;
  localparam logic [9:0] SENS_MIN = 10'h39A;
  localparam logic [9:0] SENS_MAX_EXT = 10'h1E0;
  localparam logic [9:0] SENS_MIN_EXT = 10'h220;
  localparam logic [2:0] CRC_SEED = 3'h7;
  localparam logic [3:0] CRC_POLY = 4'hB;
  localparam int DATA_BITS = 10;
  // timing in ns at 100 ns clock
  localparam int CLK_NS = 100;
  localparam int SAMPLE_NS = 200;
  localparam int QUAL_NS = 6000;
  localparam int LPF_RST_NS = 2000;
  localparam int PD_DLY_NS = 10000;
  localparam int PD_ON_NS = 20000;
  localparam int BLANK_STEP_NS = 50000;
  localparam int BIT_NS = 8000;
  localparam int SAMPLE_DIV = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int QUAL_SMP = (QUAL_NS + SAMPLE_NS - 1) / SAMPLE_NS;
  localparam int LPF_SMP = (LPF_RST_NS + SAMPLE_NS - 1) / SAMPLE_NS;
  localparam int PD_DLY_SMP = (PD_DLY_NS + SAMPLE_NS - 1) / SAMPLE_NS;
  localparam int PD_ON_SMP = (PD_ON_NS + SAMPLE_NS - 1) / SAMPLE_NS;
  localparam int BLANK_SMP = (BLANK_STEP_NS + SAMPLE_NS - 1) / SAMPLE_NS;
  localparam int HALF_BIT = BIT_NS / (2 * CLK_NS);
  localparam int MIN_SYNC_SMP = 10;
  typedef enum logic [1:0] {PSTX_IDLE, PSTX_QUAL, PSTX_BLANK} pstx_sync_e;
endpackage

/* hw/pstx_top.sv */
// pstx_top: sync detector, pulldown and manchester frame sender
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module pstx_top
  import pstx_pkg::*;
#(
  parameter int MIN_SYNC = MIN_SYNC_SMP
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sync_comp,
  output logic sync_valid,
  output logic filter_reset,
  output logic mod_current
);
  initial begin
    if (MIN_SYNC < 1 || MIN_SYNC >= QUAL_SMP) $error("MIN_SYNC out of range");
  end

  typedef struct packed {
    logic [31:0] cfg;
    logic [9:0] data;
    logic [7:0] errs;
    logic [31:0] rdata;
    logic rdy;
    logic err;
    logic s1;
    logic s2;
    logic s_prev;
    logic [3:0] div;
    pstx_sync_e st;
    logic [7:0] cnt;
    logic [15:0] tmr;
    logic [7:0] lpf;
    logic sv;
    logic pd;
    logic [4:0] nbit;
    logic [15:0] sh;
    logic [7:0] hcnt;
    logic half;
    logic mod;
    logic drv;
    logic busy;
    logic pend;
    logic [7:0] frames;
  } pstx_s;

  pstx_s q, d;

  function automatic logic [2:0] crc3(input logic [9:0] w);
    logic [2:0] r;
    logic fb;
    r = CRC_SEED;
    for (int i = 0; i < DATA_BITS + 3; i++) begin
      fb = r[2];
      r = {r[1:0], (i < DATA_BITS) ? w[i] : 1'b0};
      if (fb) r = r ^ CRC_POLY[2:0];
    end
    return r;
  endfunction

  function automatic logic [9:0] map_word(input logic [31:0] c, input logic [9:0] v,
                                          input logic [7:0] e);
    logic [9:0] w;
    logic [9:0] hi;
    logic [9:0] lo;
    w = v;
    hi = c[CFG_DEXT] ? SENS_MAX_EXT : SENS_MAX;
    lo = c[CFG_DEXT] ? SENS_MIN_EXT : SENS_MIN;
    case (c[CFG_SEL +: 3])
      SEL_SENSOR: begin
        if (!v[9] && v > hi) w = hi;
        else if (v[9] && v < lo) w = lo;
      end
      SEL_STATUS: begin
        case (v[2:0])
          3'h0: w = CODE_BUSY;
          3'h1: w = CODE_READY;
          3'h2: w = CODE_UNLOCK;
          3'h3: w = CODE_RC_OK;
          default: w = CODE_RC_ERR;
        endcase
      end
      SEL_ERROR: begin
        if (e[5]) w = CODE_SELFT;
        else if (!c[CFG_EMSG]) w = CODE_DEFECT;
        else if (e[0]) w = CODE_COMM;
        else if (e[1]) w = CODE_TEST;
        else if (e[2]) w = CODE_PRESS;
        else if (e[3]) w = CODE_TEMP;
        else w = CODE_MEM;
      end
      SEL_INITD: w = CODE_NIB_BASE | {6'h00, v[3:0]};
      SEL_INITID: w = CODE_ID_BASE | {6'h00, v[3:0]};
      default: w = v;
    endcase
    return w;
  endfunction

  logic [9:0] word;
  logic [2:0] chk;
  logic use_crc;
  logic [4:0] flen;
  logic [9:0] fmask;
  logic tick;
  logic pd_allow;
  logic [15:0] blank_len;

  always_comb begin
    d = q;
    word = map_word(q.cfg, q.data, q.errs);
    fmask = 10'h3FF >> (4'd10 - ((q.cfg[CFG_FMT +: 4] > 4'd10 || q.cfg[CFG_FMT +: 4] == 4'd0)
            ? 4'd10 : q.cfg[CFG_FMT +: 4]));
    word = word & fmask;
    use_crc = q.cfg[CFG_CRC];
    chk = use_crc ? crc3(word) : {2'b00, ^word};
    flen = use_crc ? 5'd15 : 5'd13;
    tick = (q.div == 4'(SAMPLE_DIV - 1));
    pd_allow = q.cfg[CFG_PDEN] && !q.cfg[CFG_PROG] && !q.cfg[CFG_INIT1]
               && !(q.cfg[CFG_DAISY] && !q.cfg[CFG_RUN]);
    blank_len = 16'(BLANK_SMP) * 16'({1'b0, q.cfg[CFG_BLANK +: 4]} + 5'd1);
    // apb slave, zero wait
    d.rdy = psel && !penable;
    d.err = 1'b0;
    if (psel && !penable) begin
      d.rdata = 32'h0000_0000;
      if (paddr == ADDR_CFG) d.rdata = q.cfg;
      else if (paddr == ADDR_DATA) d.rdata = {22'h00_0000, q.data};
      else if (paddr == ADDR_STATUS) d.rdata = {16'h0000, q.frames, 4'h0, q.busy,
                                                q.pd, q.st};
      else if (paddr == ADDR_ERR) d.rdata = {24'h00_0000, q.errs};
      else d.err = 1'b1;
      if (pwrite) begin
        if (paddr == ADDR_CFG) d.cfg = pwdata;
        else if (paddr == ADDR_DATA) d.data = pwdata[9:0];
        else if (paddr == ADDR_ERR) d.errs = pwdata[7:0];
      end
    end
    // sample clock divider
    d.s1 = sync_comp;
    d.s2 = q.s1;
    d.div = tick ? 4'h0 : q.div + 4'h1;
    d.sv = 1'b0;
    if (tick) begin
      d.s_prev = q.s2;
      if (q.lpf != 8'h00) d.lpf = q.lpf - 8'h01;
      if (q.st != PSTX_IDLE) d.tmr = q.tmr + 16'h0001;
      case (q.st)
        PSTX_IDLE: begin
          if (q.s2 && !q.s_prev) begin
            d.st = PSTX_QUAL;
            d.cnt = 8'h01;
            d.tmr = 16'h0001;
          end
        end
        PSTX_QUAL: begin
          if (q.s2) d.cnt = q.cnt + 8'h01;
          if (q.tmr == 16'(QUAL_SMP)) begin
            if (q.cnt > 8'(MIN_SYNC)) begin
              d.sv = 1'b1;
              d.st = PSTX_BLANK;
              d.cnt = 8'h00;
              d.lpf = 8'(LPF_SMP);
              if (!q.busy) d.pend = 1'b1;
            end else begin
              d.st = PSTX_IDLE;
              d.tmr = 16'h0000;
              d.cnt = 8'h00;
              d.s_prev = 1'b0;
            end
          end
        end
        PSTX_BLANK: begin
          d.cnt = 8'h00;
          if (q.tmr >= blank_len) begin
            d.st = PSTX_IDLE;
            d.tmr = 16'h0000;
          end
        end
        default: d.st = PSTX_IDLE;
      endcase
      // pulldown window referenced to the time reference
      d.pd = pd_allow && q.st == PSTX_BLANK && q.tmr >= 16'(PD_DLY_SMP)
             && q.tmr < 16'(PD_DLY_SMP + PD_ON_SMP);
    end
    // manchester frame sender
    if (!q.busy && q.pend) begin
      d.pend = 1'b0;
      d.busy = 1'b1;
      d.nbit = 5'h00;
      d.half = 1'b0;
      d.hcnt = 8'h00;
      d.sh = 16'h0000;
      d.sh[1:0] = 2'b00;
      d.sh[11:2] = word;
      d.sh[14:12] = use_crc ? {chk[0], chk[1], chk[2]} : {2'b00, chk[0]};
      d.mod = 1'b0;
    end else if (q.busy) begin
      if (q.hcnt == 8'(HALF_BIT - 1)) begin
        d.hcnt = 8'h00;
        if (!q.half) begin
          d.half = 1'b1;
          d.mod = !q.sh[q.nbit[3:0]];
        end else begin
          d.half = 1'b0;
          if (q.nbit == flen - 5'd1) begin
            d.busy = 1'b0;
            d.mod = 1'b0;
            d.frames = q.frames + 8'h01;
          end else begin
            d.nbit = q.nbit + 5'd1;
            d.mod = q.sh[q.nbit[3:0] + 4'h1];
          end
        end
      end else begin
        d.hcnt = q.hcnt + 8'h01;
      end
    end
    // pulldown shares the modulation sink
    d.drv = d.mod || d.pd;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.cfg <= CFG_RESET;
      q.st <= PSTX_IDLE;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.rdy;
  assign pslverr = q.err;
  assign sync_valid = q.sv;
  assign filter_reset = q.lpf != 8'h00;
  assign mod_current = q.drv;

  crc_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    crc3(10'h000) == 3'b110 && crc3(10'h3FF) == 3'b100) else $error("crc vector");
  pd_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.pd |-> $past(pd_allow)) else $error("pulldown while forbidden");
  sv_blank_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.sv |-> q.st == PSTX_BLANK && filter_reset) else $error("valid without blank");
  frame_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.busy |-> q.nbit < 5'd15) else $error("frame too long");
  idle_mod_a: assert property (@(posedge pclk) disable iff (!presetn)
    !q.busy && !$past(q.busy) |-> !q.mod) else $error("not idle");

  sv_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    q.sv
    |=> !q.sv
  ) else $error("valid sync longer than one cycle");

  lpf_load_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    q.sv
    |-> q.lpf == 8'(LPF_SMP)
  ) else $error("filter reset not loaded");

  blank_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    q.st == PSTX_BLANK
    |-> q.cnt == 8'h00
  ) else $error("counter active while blanked");

  idle_tmr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    q.st == PSTX_IDLE
    |-> q.tmr == 16'h0000
  ) else $error("timer running while idle");

  pd_drive_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    q.pd
    |-> mod_current
  ) else $error("pulldown without sink current");

  mid_bit_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    q.busy && !q.half && q.hcnt == 8'(HALF_BIT - 1)
    |=> q.mod != $past(q.mod)
  ) else $error("no mid-bit transition");

  boundary_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    q.busy && q.half && q.hcnt == 8'(HALF_BIT - 1) && q.nbit != flen - 5'd1
      && q.sh[q.nbit[3:0]] == q.sh[q.nbit[3:0] + 4'h1]
    |=> q.mod != $past(q.mod)
  ) else $error("no boundary transition");

  frame_start_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !q.busy && q.pend
    |=> q.busy && q.nbit == 5'h00 && q.sh[1:0] == 2'b00
  ) else $error("frame start wrong");

  lsb_first_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !q.busy && q.pend
    |=> q.sh[11:2] == $past(word)
  ) else $error("data word misplaced");

  parity_even_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !q.busy && q.pend && !use_crc
    |=> ^q.sh[12:2] == 1'b0
  ) else $error("parity not even");

  crc_order_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !q.busy && q.pend && use_crc
    |=> q.sh[14:12] == {$past(chk[0]), $past(chk[1]), $past(chk[2])}
  ) else $error("crc bits misplaced");

  qual_enter_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick && q.st == PSTX_IDLE && q.s2 && !q.s_prev
    |=> q.st == PSTX_QUAL && q.cnt == 8'h01
  ) else $error("candidate not started");

  fail_idle_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick && q.st == PSTX_QUAL && q.tmr == 16'(QUAL_SMP) && q.cnt <= 8'(MIN_SYNC)
    |=> q.st == PSTX_IDLE
  ) else $error("failed candidate not re-armed");

  valid_qual_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    q.sv
    |-> $past(q.cnt) > 8'(MIN_SYNC)
  ) else $error("valid sync below limit");

  fmt_mask_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !q.busy && q.pend
    |=> (q.sh[11:2] & ~$past(fmask)) == 10'h000
  ) else $error("field size not applied");
endmodule // pstx_top
`default_nettype wire

/* dv/pstx_master_model.sv */
// pstx_master_model: bus master model, sync pulses out, frame decode in
`timescale 1ns/1ns
`default_nettype none
module pstx_master_model
  import pstx_pkg::*;
(
  input wire logic pclk,
  input wire logic mod_current,
  output logic sync_comp
);
  initial sync_comp = 1'b0;
  // supply raised for n clocks
  task automatic sync(input int n);
    @(posedge pclk);
    sync_comp <= 1'b1;
    repeat (n) @(posedge pclk);
    sync_comp <= 1'b0;
  endtask
  // find first mid-bit rise, then sample the second half of every bit and the half after it
  task automatic grab(input int nb, output logic [14:0] bits, output logic ok);
    logic [30:0] s;
    int i;
    ok = 1'b0;
    bits = 15'h0000;
    s = 31'h0000_0000;
    for (i = 0; i < 4000 && !ok; i++) begin
      @(posedge pclk);
      ok = (mod_current === 1'b1);
    end
    repeat (HALF_BIT / 2) @(posedge pclk);
    for (i = 0; i < 2 * nb; i++) begin
      s[i] = mod_current;
      repeat (HALF_BIT) @(posedge pclk);
    end
    for (i = 0; i < nb; i++) begin
      bits[i] = ~s[2 * i];
      if (s[2 * i + 1] !== (i == nb - 1 ? 1'b0 : ~s[2 * i + 2])) ok = 1'b0;
    end
  endtask
endmodule // pstx_master_model
`default_nettype wire

/* dv/test_pstx_top.sv */
// test_pstx_top: self-checking bench for the sensor link transmitter
`timescale 1ns/1ns
`default_nettype none
module test_pstx_top
  import pstx_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, sync_comp, sync_valid, filter_reset, mod_current, last_err;
  int n_mismatch = 0, total_checks = 0, n_sv = 0;
  always #50 pclk = ~pclk;
  always @(posedge pclk) if (sync_valid === 1'b1) n_sv++;
  pstx_top u_pstx_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sync_comp(sync_comp), .sync_valid(sync_valid),
    .filter_reset(filter_reset), .mod_current(mod_current));
  pstx_master_model u_pstx_master_model (.pclk(pclk), .mod_current(mod_current),
    .sync_comp(sync_comp));
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 40) begin
      chk(0, 1, "apb timeout");
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  function automatic logic [2:0] crc3(input logic [9:0] d);
    logic [2:0] c;
    logic [12:0] m;
    c = 3'h7;
    m = {3'h0, d};
    for (int k = 0; k < 13; k++) c = {c[1:0], m[k]} ^ (c[2] ? 3'h3 : 3'h0);
    return c;
  endfunction
  task automatic frame(input logic [31:0] cfg, input logic [9:0] dat, input logic [9:0] exp);
    logic [14:0] b;
    logic ok;
    int s;
    wr(ADDR_CFG, cfg);
    wr(ADDR_DATA, {22'h0, dat});
    s = n_sv;
    u_pstx_master_model.sync(24);
    u_pstx_master_model.grab(cfg[CFG_CRC] ? 15 : 13, b, ok);
    chk(n_sv - s, 1, "one valid sync");
    chk(ok, 1, "manchester shape");
    chk(b[1:0], 0, "start bits");
    chk(b[11:2], exp, "data word");
    if (cfg[CFG_CRC]) chk({b[12], b[13], b[14]}, crc3(exp), "crc");
    else chk(b[12], ^exp, "even parity");
  endtask
  task automatic t_regs();
    logic [31:0] r;
    apb(1'b0, ADDR_CFG, 32'h0000_0000, r);
    chk(r, CFG_RESET, "cfg reset");
    apb(1'b0, 8'h10, 32'h0000_0000, r);
    chk(last_err, 1, "unmapped error");
    chk(r, 0, "unmapped data");
    wr(ADDR_DATA, 32'h0000_02AA);
    apb(1'b0, ADDR_DATA, 32'h0000_0000, r);
    chk(r[9:0], 10'h2AA, "data readback");
  endtask
  task automatic t_parity();
    frame(32'h0000_0000, 10'h0C4, 10'h0C4);
    frame(32'h0000_0000, 10'h1E0, SENS_MAX);
    frame(32'h0000_0000, 10'h220, SENS_MIN);
  endtask
  task automatic t_crc();
    logic [9:0] v [5] = '{10'h000, 10'h0CC, 10'h151, 10'h220, 10'h3FF};
    for (int i = 0; i < 5; i++) frame(32'h0000_0005, v[i], v[i]);
  endtask
  task automatic t_codes();
    logic [9:0] st [5] = '{CODE_BUSY, CODE_READY, CODE_UNLOCK, CODE_RC_OK, CODE_RC_ERR};
    logic [31:0] ec [5] = '{32'h0000_0002, 32'h0000_0002, 32'h0000_0002, 32'h0, 32'h0};
    int fl [5] = '{0, 4, 5, 2, 5};
    logic [9:0] ee [5] = '{CODE_COMM, CODE_MEM, CODE_SELFT, CODE_DEFECT, CODE_SELFT};
    for (int i = 0; i < 5; i++) frame(32'(SEL_STATUS) << CFG_SEL, 10'(i), st[i]);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_ERR, 32'h0000_0001 << fl[i]);
      frame(ec[i] | (32'(SEL_ERROR) << CFG_SEL), 10'h000, ee[i]);
    end
    wr(ADDR_ERR, 32'h0000_0000);
  endtask
  task automatic t_short();
    int s;
    s = n_sv;
    u_pstx_master_model.sync(18);
    repeat (80) @(posedge pclk);
    chk(n_sv - s, 0, "short pulse");
    frame(32'h0000_0000, 10'h001, 10'h001);
  endtask
  task automatic t_pull();
    logic [31:0] cf [5] = '{32'h0000_0088, 32'h0000_0018, 32'h0000_0028, 32'h0000_0048,
      32'h0000_00C8};
    logic pe [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    logic [31:0] r;
    int s, j;
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_CFG, cf[i]);
      s = n_sv;
      u_pstx_master_model.sync(24);
      for (j = 0; j < 200 && n_sv == s; j++) @(posedge pclk);
      repeat (5) @(posedge pclk);
      chk(filter_reset, 1, "filter held");
      repeat (135) @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 32'h0000_0000, r);
      chk(r[2], pe[i], "pulldown level");
      if (pe[i]) chk(mod_current, 1, "pulldown current");
      chk(filter_reset, 0, "filter released");
      u_pstx_master_model.sync(24);
      repeat (135) @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 32'h0000_0000, r);
      chk(r[2], 0, "pulldown off");
      repeat (2600) @(posedge pclk);
      chk(n_sv - s, 1, "sync blanked");
    end
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_parity();
    t_crc();
    t_codes();
    t_short();
    t_pull();
    summarize();
  end
endmodule // test_pstx_top
`default_nettype wire
